//--- rtl/ttcm_map.vh
`ifndef TTCM_MAP_VH
`define TTCM_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TTCM_OFS_CTRL_A 8'h00
`define TTCM_OFS_CTRL_C 8'h04
`define TTCM_OFS_CTRL_B 8'h08
`define TTCM_OFS_CNT_A 8'h0C
`define TTCM_OFS_CNT_C 8'h10
`define TTCM_OFS_CNT_B 8'h14
`define TTCM_OFS_STAT 8'h18
`define TTCM_OFS_MASK 8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define TTCM_F_MODE_LO 0
`define TTCM_F_RUN 3
`define TTCM_F_DOWN 4
`define TTCM_F_EXTUD 5
`define TTCM_F_PRE_LO 6
`define TTCM_F_EDGE_LO 9
`define TTCM_F_GATEHI 11
`define TTCM_F_OUTEN 12
`define TTCM_F_RLSEL_LO 13
`define TTCM_F_CAPIN 15
`define TTCM_F_CAPUD 16
// ----------------------------------------
// modes and reset values
// ----------------------------------------
`define TTCM_M_TIMER 3'h0
`define TTCM_M_COUNTER 3'h1
`define TTCM_M_GATED 3'h2
`define TTCM_M_ENCODER 3'h3
`define TTCM_M_RELOAD 3'h4
`define TTCM_M_CAPTURE 3'h5
`define TTCM_RST_CTRL 32'h0000_0000
`define TTCM_BASE_DIV 16
`endif

//--- rtl/ttcm_timers.v
`timescale 1ns/1ns
`include "ttcm_map.vh"
// Overview of operation
// - three 16-bit timers, optionally chained
// - four counting modes per timer selectable, aux timers add reload and capture
// - timer mode counts prescaled cpu clock
// - counter mode counts count pin events
// - gated mode counts while gate active
// - finest resolution one count per 16
// - software direction, optional updown pin override
// - encoder mode decodes sensor A and B
// - core toggle latch flips, drives pin
// - toggle latch may clock aux timers
// - aux as capture/reload stops counting
// - capture copies core value on pin
// - reload on pin or latch edge
// - alternating reloads give hands-free PWM
// - core pin edges exported as capture trigger
module ttcm_timers #(
  parameter W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timer pins, index 0 aux a, 1 core, 2 aux b
  input wire [2:0] timer_count_gate_pin,
  input wire [2:0] timer_updown_pin,
  output reg core_toggle_out_pin,
  // capture trigger to the second timer module
  output reg capture_trigger,
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // pin synchronisers and edge history
  // ----------------------------------------
  reg [2:0] cin_m_r, cin_s_r, cin_d_r;
  reg [2:0] udp_m_r, udp_s_r, udp_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cin_m_r <= 3'h0;
      cin_s_r <= 3'h0;
      cin_d_r <= 3'h0;
      udp_m_r <= 3'h0;
      udp_s_r <= 3'h0;
      udp_d_r <= 3'h0;
    end else begin
      cin_m_r <= timer_count_gate_pin;
      cin_s_r <= cin_m_r;
      cin_d_r <= cin_s_r;
      udp_m_r <= timer_updown_pin;
      udp_s_r <= udp_m_r;
      udp_d_r <= udp_s_r;
    end
  end
  wire [2:0] cin_rise = cin_s_r & ~cin_d_r;
  wire [2:0] cin_fall = ~cin_s_r & cin_d_r;
  wire [2:0] udp_chg = udp_s_r ^ udp_d_r;

  // ----------------------------------------
  // base prescaler
  // ----------------------------------------
  // free 16-bit divider; select bit k gives one tick per 16 << k cycles
  reg [15:0] div_r;
  reg [15:0] div_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 16'h0000;
      div_d_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
      div_d_r <= div_r;
    end
  end
  wire [15:0] div_tick = div_r & ~div_d_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl_r [0:2];
  reg [W-1:0] cnt_r [0:2];
  reg [5:0] stat_r;
  reg [5:0] mask_r;
  reg otl_r;
  reg otl_d_r;

  // pick the edges that count in counter mode: 1 rise, 2 fall, 3 both
  function sel_edge;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      sel_edge = (sel[0] & rise) | (sel[1] & fall);
    end
  endfunction

  wire [2:0] mode [0:2];
  wire [2:0] tick;
  wire [2:0] down;
  wire [2:0] ovf;
  wire [2:0] unf;
  wire [2:0] otl_edge_hit;
  wire otl_rise = otl_r & ~otl_d_r;
  wire otl_fall = ~otl_r & otl_d_r;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : tmr
      wire [2:0] m = ctrl_r[g][`TTCM_F_MODE_LO +: 3];
      wire [2:0] ps = ctrl_r[g][`TTCM_F_PRE_LO +: 3];
      wire [1:0] es = ctrl_r[g][`TTCM_F_EDGE_LO +: 2];
      wire run = ctrl_r[g][`TTCM_F_RUN];
      wire pre_tick = div_tick[4'd3 + {1'b0, ps}];
      wire gate_on = cin_s_r[g] ~^ ctrl_r[g][`TTCM_F_GATEHI];
      // encoder: A on count pin, B on updown pin, count on every A or B edge
      wire enc_tick = (cin_s_r[g] ^ cin_d_r[g]) | udp_chg[g];
      wire enc_down = (cin_s_r[g] ^ cin_d_r[g]) ? (cin_s_r[g] == udp_s_r[g])
        : (cin_s_r[g] != udp_s_r[g]);
      // aux timers may instead count core toggle latch edges
      wire otl_src = (g != 1) && es == 2'h0;
      wire ext_tick = otl_src ? (otl_rise | otl_fall)
        : sel_edge(es, cin_rise[g], cin_fall[g]);
      wire any_tick = (m == `TTCM_M_TIMER) ? pre_tick :
        (m == `TTCM_M_GATED) ? (pre_tick & gate_on) :
        (m == `TTCM_M_COUNTER) ? ext_tick :
        (m == `TTCM_M_ENCODER) ? enc_tick : 1'b0;
      assign mode[g] = m;
      assign tick[g] = run & any_tick;
      // the pin level flips direction when the override is enabled
      assign down[g] = (m == `TTCM_M_ENCODER) ? enc_down :
        ctrl_r[g][`TTCM_F_DOWN] ^ (ctrl_r[g][`TTCM_F_EXTUD] & udp_s_r[g]);
      assign ovf[g] = tick[g] & ~down[g] & (&cnt_r[g]);
      assign unf[g] = tick[g] & down[g] & ~(|cnt_r[g]);
      // reload select: 0 pin rise, 1 latch rise, 2 latch fall, 3 latch either
      wire [1:0] rs = ctrl_r[g][`TTCM_F_RLSEL_LO +: 2];
      assign otl_edge_hit[g] = (rs == 2'h0) ? cin_rise[g] :
        (rs == 2'h1) ? otl_rise : (rs == 2'h2) ? otl_fall : (otl_rise | otl_fall);
    end
  endgenerate

  wire rld_a = (mode[0] == `TTCM_M_RELOAD) & otl_edge_hit[0];
  wire rld_b = (mode[2] == `TTCM_M_RELOAD) & otl_edge_hit[2];
  wire cap_a = (mode[0] == `TTCM_M_CAPTURE) & cin_rise[0];
  wire cap_b = (mode[2] == `TTCM_M_CAPTURE) & cin_rise[2];

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  reg aw_hold_r, w_hold_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire aw_ok = aw_hold_r | (s_axi_awvalid & s_axi_awready);
  wire w_ok = w_hold_r | (s_axi_wvalid & s_axi_wready);
  wire wr_go = aw_ok & w_ok;
  wire [7:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
  wire rd_go = s_axi_arvalid & s_axi_arready;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function valid_addr;
    input [7:0] a;
    begin
      valid_addr = (a[1:0] == 2'h0) && (a <= `TTCM_OFS_MASK);
    end
  endfunction

  wire [31:0] cnt_ext [0:2];
  assign cnt_ext[0] = {{(32-W){1'b0}}, cnt_r[0]};
  assign cnt_ext[1] = {{(32-W){1'b0}}, cnt_r[1]};
  assign cnt_ext[2] = {{(32-W){1'b0}}, cnt_r[2]};
  wire wr_stat = wr_go & (wa == `TTCM_OFS_STAT);
  wire rd_stat = rd_go & (s_axi_araddr == `TTCM_OFS_STAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= valid_addr(wa) ? 2'h0 : 2'h2;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_hold_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_hold_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= valid_addr(s_axi_araddr) ? 2'h0 : 2'h2;
        if (s_axi_araddr == `TTCM_OFS_CTRL_A) begin
          s_axi_rdata <= ctrl_r[0];
        end else if (s_axi_araddr == `TTCM_OFS_CTRL_C) begin
          s_axi_rdata <= ctrl_r[1];
        end else if (s_axi_araddr == `TTCM_OFS_CTRL_B) begin
          s_axi_rdata <= ctrl_r[2];
        end else if (s_axi_araddr == `TTCM_OFS_CNT_A) begin
          s_axi_rdata <= cnt_ext[0];
        end else if (s_axi_araddr == `TTCM_OFS_CNT_C) begin
          s_axi_rdata <= cnt_ext[1];
        end else if (s_axi_araddr == `TTCM_OFS_CNT_B) begin
          s_axi_rdata <= cnt_ext[2];
        end else if (s_axi_araddr == `TTCM_OFS_STAT) begin
          s_axi_rdata <= {26'h0, stat_r};
        end else if (s_axi_araddr == `TTCM_OFS_MASK) begin
          s_axi_rdata <= {26'h0, mask_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control, status and mask
  // ----------------------------------------
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 3; k = k + 1)
        ctrl_r[k] <= `TTCM_RST_CTRL;
      mask_r <= 6'h00;
      stat_r <= 6'h00;
    end else begin
      for (k = 0; k < 3; k = k + 1)
        if (wr_go && wa == `TTCM_OFS_CTRL_A + 8'h04 * k[7:0])
          ctrl_r[k] <= merge(ctrl_r[k], wd, ws);
      if (wr_go && wa == `TTCM_OFS_MASK)
        mask_r <= wd[5:0];
      // read clears, a wrap in the same cycle still lands
      stat_r <= (rd_stat ? 6'h00 : stat_r) | {unf, ovf};
    end
  end
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------
  // counters and core toggle latch
  // ----------------------------------------
  // aux a and aux b chained onto the core overflow or underflow via counter mode on latch
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r[0] <= {W{1'b0}};
      cnt_r[1] <= {W{1'b0}};
      cnt_r[2] <= {W{1'b0}};
      otl_r <= 1'b0;
      otl_d_r <= 1'b0;
      core_toggle_out_pin <= 1'b0;
      capture_trigger <= 1'b0;
    end else begin
      otl_d_r <= otl_r;
      if (ovf[1] | unf[1])
        otl_r <= ~otl_r;
      core_toggle_out_pin <= ctrl_r[1][`TTCM_F_OUTEN] & otl_r;
      capture_trigger <= (ctrl_r[1][`TTCM_F_CAPIN] & (cin_s_r[1] ^ cin_d_r[1]))
        | (ctrl_r[1][`TTCM_F_CAPUD] & udp_chg[1]);
      if (wr_go && wa == `TTCM_OFS_CNT_A) begin
        cnt_r[0] <= wd[W-1:0];
      end else if (cap_a) begin
        cnt_r[0] <= cnt_r[1];
      end else if (tick[0]) begin
        cnt_r[0] <= down[0] ? cnt_r[0] - 1'b1 : cnt_r[0] + 1'b1;
      end
      if (wr_go && wa == `TTCM_OFS_CNT_B) begin
        cnt_r[2] <= wd[W-1:0];
      end else if (cap_b) begin
        cnt_r[2] <= cnt_r[1];
      end else if (tick[2]) begin
        cnt_r[2] <= down[2] ? cnt_r[2] - 1'b1 : cnt_r[2] + 1'b1;
      end
      // aux a wins if both reload together; opposite latch edges give pwm
      if (wr_go && wa == `TTCM_OFS_CNT_C) begin
        cnt_r[1] <= wd[W-1:0];
      end else if (rld_a) begin
        cnt_r[1] <= cnt_r[0];
      end else if (rld_b) begin
        cnt_r[1] <= cnt_r[2];
      end else if (tick[1]) begin
        cnt_r[1] <= down[1] ? cnt_r[1] - 1'b1 : cnt_r[1] + 1'b1;
      end
    end
  end

endmodule

//--- bench/ttcm_timers_chk.sv
`timescale 1ns/1ns
module ttcm_timers_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire core_toggle_out_pin,
  input wire capture_trigger,
  input wire irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq
      && !capture_trigger && !core_toggle_out_pin;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bblock;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_bblock: assert property (p_bblock) else $error("address taken during response");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblock: assert property (p_rblock) else $error("read taken during answer");
  property p_slverr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_cap;
    capture_trigger |=> !capture_trigger;
  endproperty
  a_cap: assert property (p_cap) else $error("capture trigger too long");
  // the latch moves on count ticks; the check holds it for 8 cycles after each move, half the base resolution
  property p_tog;
    $changed(core_toggle_out_pin) |=> $stable(core_toggle_out_pin)[*8];
  endproperty
  a_tog: assert property (p_tog) else $error("toggle pin moved too fast");
endmodule

//--- bench/ttcm_sensor.sv
`timescale 1ns/1ns
module ttcm_sensor (
  // clock
  input wire aclk,
  // event, gate and sensor lines
  output reg [2:0] cnt_pin,
  output reg [2:0] ud_pin
);
  initial begin
    cnt_pin = 3'h0;
    ud_pin = 3'h0;
  end
  // four cycles per level so every change outlives the pin synchroniser
  task hold;
    repeat (4) @(posedge aclk);
  endtask
  task set(input integer i, input reg c, input reg u);
    begin
      @(posedge aclk);
      cnt_pin[i] <= c;
      ud_pin[i] <= u;
      hold;
    end
  endtask
  task pulse(input integer i, input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      cnt_pin[i] <= 1'b1;
      hold;
      cnt_pin[i] <= 1'b0;
      hold;
    end
  endtask
  // a and b a quarter period apart; forward leads with a
  task quad(input integer i, input integer fwd, input integer n);
    integer j;
    for (j = 0; j < 4 * n; j = j + 1) begin
      if ((j % 2 == 0) == (fwd != 0))
        cnt_pin[i] <= ~cnt_pin[i];
      else
        ud_pin[i] <= ~ud_pin[i];
      hold;
    end
  endtask
endmodule

//--- bench/tb_three_timer_counter_module.sv
`timescale 1ns/1ns
`include "ttcm_map.vh"
module tb_three_timer_counter_module;
  localparam [31:0] RUN = 32'h8;
  localparam [31:0] OUTEN = 32'h1000;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, tog, capt, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] cpin, upin;
  integer err_total = 0;
  integer cmp_count = 0;
  integer ncap = 0;
  integer k, n0;
  reg [31:0] rv;
  reg [1:0] rr;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (capt) ncap <= ncap + 1;
  ttcm_timers dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_count_gate_pin(cpin), .timer_updown_pin(upin),
    .core_toggle_out_pin(tog), .capture_trigger(capt), .irq(irq));
  ttcm_sensor sen_u (.aclk(aclk), .cnt_pin(cpin), .ud_pin(upin));
  task wrap_up;
    begin
      if (err_total == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        $display("CHECK FAILED %0s expected %h seen %h", n, e, g);
        err_total = err_total + 1;
      end
    end
  endtask
  // each channel is released at the edge that takes it; bready stands until bvalid
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bready && bvalid) bready <= 1'b0;
      end while (awvalid || wvalid || bready);
    end
  endtask
  // read data is taken at the very edge where rvalid and rready meet
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rready && rvalid) begin
          rv = rdata;
          rr = rresp;
          rready <= 1'b0;
        end
      end while (arvalid || rready);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk("register", e, rv);
    end
  endtask
  // about ten prescaler ticks of 16 or 32 cycles, phase of the prescaler unknown
  task rg(input [7:0] a);
    begin
      rd(a);
      chk("tick count", 1, {31'h0, rv >= 9 && rv <= 11});
    end
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`TTCM_OFS_CTRL_C, `TTCM_RST_CTRL);
    rd(8'h20);
    chk("unmapped resp", 2, rr);
    wr(`TTCM_OFS_MASK, 32'h3F);
    wr(`TTCM_OFS_CNT_C, 32'hFFFF);
    wr(`TTCM_OFS_CTRL_C, RUN | OUTEN);
    repeat (40) @(posedge aclk);
    chk("toggle pin", 1, tog);
    chk("irq", 1, irq);
    rc(`TTCM_OFS_STAT, 32'h2);
    rc(`TTCM_OFS_STAT, 32'h0);
    chk("irq", 0, irq);
    for (k = 0; k < 2; k = k + 1) begin
      wr(`TTCM_OFS_CTRL_C, k << 6);
      wr(`TTCM_OFS_CNT_C, 32'h0);
      wr(`TTCM_OFS_CTRL_C, RUN | k << 6);
      repeat (160 << k) @(posedge aclk);
      rg(`TTCM_OFS_CNT_C);
    end
    sen_u.set(1, 1'b0, 1'b1);
    for (k = 0; k < 2; k = k + 1) begin
      wr(`TTCM_OFS_CNT_C, 32'h0);
      wr(`TTCM_OFS_CTRL_C, RUN | (k ? 32'h20 : 32'h10));
      repeat (40) @(posedge aclk);
      wr(`TTCM_OFS_CTRL_C, 32'h0);
      rc(`TTCM_OFS_STAT, 32'h10);
    end
    wr(`TTCM_OFS_CNT_A, 32'h0);
    wr(`TTCM_OFS_CTRL_A, RUN | `TTCM_M_COUNTER | 32'h200);
    sen_u.pulse(0, 5);
    rc(`TTCM_OFS_CNT_A, 32'h5);
    wr(`TTCM_OFS_CTRL_B, RUN | `TTCM_M_ENCODER);
    wr(`TTCM_OFS_CNT_B, 32'h0);
    sen_u.quad(2, 1, 2);
    rd(`TTCM_OFS_CNT_B);
    chk("encoder", 1, {31'h0, rv == 8 || rv == 32'hFFF8});
    sen_u.quad(2, 0, 2);
    rc(`TTCM_OFS_CNT_B, 32'h0);
    wr(`TTCM_OFS_CTRL_B, RUN | `TTCM_M_GATED | 32'h800);
    repeat (100) @(posedge aclk);
    rc(`TTCM_OFS_CNT_B, 32'h0);
    sen_u.set(2, 1'b1, 1'b0);
    repeat (156) @(posedge aclk);
    sen_u.set(2, 1'b0, 1'b0);
    rg(`TTCM_OFS_CNT_B);
    wr(`TTCM_OFS_CNT_C, 32'h42);
    wr(`TTCM_OFS_CTRL_B, RUN | `TTCM_M_CAPTURE);
    wr(`TTCM_OFS_CNT_B, 32'h1234);
    repeat (40) @(posedge aclk);
    rc(`TTCM_OFS_CNT_B, 32'h1234);
    sen_u.pulse(2, 1);
    rc(`TTCM_OFS_CNT_B, 32'h42);
    wr(`TTCM_OFS_CTRL_A, RUN | `TTCM_M_RELOAD);
    wr(`TTCM_OFS_CNT_A, 32'h777);
    sen_u.pulse(0, 1);
    rc(`TTCM_OFS_CNT_C, 32'h777);
    wr(`TTCM_OFS_CTRL_C, 32'h8000);
    n0 = ncap;
    sen_u.pulse(1, 1);
    chk("capture pulses", 1, {31'h0, ncap > n0});
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total = err_total + 1;
    wrap_up;
  end
endmodule
bind ttcm_timers ttcm_timers_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
  .core_toggle_out_pin(core_toggle_out_pin), .capture_trigger(capture_trigger));
